/* File: hw/tcc_pkg.sv */
// constants, field layout and mode type of the timer channel control block
// assumes one AHB-Lite master and a 250 MHz bus clock
package tcc_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] TCC_OFS_CSC      = 8'h00;
	localparam logic [7:0] TCC_OFS_CTRL     = 8'h04;
	localparam logic [7:0] TCC_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] TCC_OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] TCC_OFS_PIN_STAT = 8'h10;

	// ==========================================================
	// channel_status_control, control, interrupt and pin status fields
	localparam int TCC_CSC_FLAG_BIT = 7;
	localparam int TCC_CSC_IE_BIT   = 6;
	localparam int TCC_CSC_MSH_BIT  = 5;
	localparam int TCC_CSC_MSL_BIT  = 4;
	localparam int TCC_CSC_ELS_HI   = 3;
	localparam int TCC_CSC_ELS_LO   = 2;
	localparam int TCC_CTRL_CPWM_BIT = 0;
	localparam int TCC_IRQ_EV_BIT   = 0;
	localparam int TCC_PIN_LVL_BIT  = 0;
	localparam int TCC_PIN_OUT_BIT  = 1;
	localparam int TCC_PIN_OE_BIT   = 2;

	// ==========================================================
	// reset values and encodings
	localparam logic [7:0] TCC_CSC_RST      = 8'h00;
	localparam logic       TCC_CTRL_RST     = 1'h0;
	localparam logic       TCC_IRQ_RST      = 1'h0;
	localparam logic       TCC_PIN_RST      = 1'h0;
	localparam logic [1:0] TCC_ELS_OFF      = 2'h0;
	localparam logic [1:0] TCC_ELS_TOGGLE   = 2'h1;
	localparam logic [1:0] TCC_ELS_CLEAR    = 2'h2;
	localparam logic [1:0] TCC_ELS_SET      = 2'h3;
	localparam logic [1:0] TCC_HTRANS_NSEQ  = 2'h2;
	localparam logic [1:0] TCC_HRESP_OKAY   = 2'h0;

	// ==========================================================
	// channel operating modes
	typedef enum logic [3:0] {
		TCC_M_CAPTURE = 4'h1,
		TCC_M_COMPARE = 4'h2,
		TCC_M_EPWM    = 4'h4,
		TCC_M_CPWM    = 4'h8
	} tcc_mode_t;

endpackage

/* File: hw/tcc_pin_edge.sv */
// channel pin synchroniser and selectable edge detector
// assumes the pin is asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_edge (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_async,
	input  wire logic rise_en,
	input  wire logic fall_en,
	output logic      pin_level,
	output logic      edge_hit
);
	import tcc_pkg::*;

	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	logic hit_r;
	logic hit_nxt;

	// ==========================================================
	// edge detection on the second stage against the third (prev_r)
	always_comb begin
		hit_nxt = (rise_en && sync2_r && !prev_r) ||
			(fall_en && !sync2_r && prev_r);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= TCC_PIN_RST;
			sync2_r <= TCC_PIN_RST;
			prev_r  <= TCC_PIN_RST;
			hit_r   <= 1'b0;
		end else begin
			sync1_r <= pin_async;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
			hit_r   <= hit_nxt;
		end
	end

	assign pin_level = prev_r;
	assign edge_hit  = hit_r;

endmodule
`default_nettype wire

/* File: hw/tcc_channel.sv */
// one timer channel: status/control register, pin action, interrupts
// assumes AHB-Lite single word transfers; counter match, wrap and
// direction come as same-clock pulses/levels from the shared counter
`timescale 1ns/1ps
`default_nettype none
module tcc_channel (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	input  wire logic        ch_pin_in,
	output logic             ch_pin_out,
	output logic             ch_pin_oe,
	input  wire logic        cnt_match,
	input  wire logic        cnt_wrap,
	input  wire logic        cnt_down,
	output logic             ch_irq,
	output logic             irq
);
	import tcc_pkg::*;

	function automatic tcc_mode_t tcc_mode(input logic cpwm,
		input logic msh, input logic msl);
		tcc_mode_t m;
		if (cpwm)
			m = TCC_M_CPWM;
		else if (msh)
			m = TCC_M_EPWM;
		else if (msl)
			m = TCC_M_COMPARE;
		else
			m = TCC_M_CAPTURE;
		return m;
	endfunction

	// ==========================================================
	// state
	logic        flag_r,   flag_nxt;
	logic        ie_r,     ie_nxt;
	logic        msh_r,    msh_nxt;
	logic        msl_r,    msl_nxt;
	logic [1:0]  els_r,    els_nxt;
	logic        cpwm_r,   cpwm_nxt;
	logic        armed_r,  armed_nxt;
	logic        ist_r,    ist_nxt;
	logic        imask_r,  imask_nxt;
	logic        pout_r,   pout_nxt;
	logic        poe_r,    poe_nxt;
	logic        chirq_r,  chirq_nxt;
	logic        irq_r,    irq_nxt;
	logic [31:0] rdata_r,  rdata_nxt;
	logic        wpend_r,  wpend_nxt;
	logic [7:0]  waddr_r,  waddr_nxt;
	logic        hrdy_r;
	logic        ev;
	logic        acc;
	logic        rd_csc;
	logic        wr_csc;
	logic        edge_hit;
	logic        pin_level;
	tcc_mode_t   mode;
	tcc_mode_t   mode_nxt;

	// ==========================================================
	// pin synchroniser and edge selection
	tcc_pin_edge u_edge (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_async (ch_pin_in),
		.rise_en   (els_r[0]),
		.fall_en   (els_r[1]),
		.pin_level (pin_level),
		.edge_hit  (edge_hit)
	);

	// ==========================================================
	// next-state logic
	always_comb begin
		mode = tcc_mode(cpwm_r, msh_r, msl_r);
		acc = hsel && hready && htrans[1];
		wr_csc = wpend_r && (waddr_r == TCC_OFS_CSC);
		rd_csc = acc && !hwrite && (haddr[7:0] == TCC_OFS_CSC);
		wpend_nxt = acc && hwrite;
		waddr_nxt = acc ? haddr[7:0] : waddr_r;

		unique case (mode)
			TCC_M_CAPTURE: ev = edge_hit && (els_r != TCC_ELS_OFF);
			TCC_M_COMPARE: ev = cnt_match;
			TCC_M_EPWM:    ev = cnt_match;
			TCC_M_CPWM:    ev = cnt_match;
		endcase

		ie_nxt   = ie_r;
		msh_nxt  = msh_r;
		msl_nxt  = msl_r;
		els_nxt  = els_r;
		cpwm_nxt = cpwm_r;
		imask_nxt = imask_r;
		if (wr_csc) begin
			ie_nxt  = hwdata[TCC_CSC_IE_BIT];
			msh_nxt = hwdata[TCC_CSC_MSH_BIT];
			msl_nxt = hwdata[TCC_CSC_MSL_BIT];
			els_nxt = hwdata[TCC_CSC_ELS_HI:TCC_CSC_ELS_LO];
		end
		if (wpend_r && waddr_r == TCC_OFS_CTRL)
			cpwm_nxt = hwdata[TCC_CTRL_CPWM_BIT];
		if (wpend_r && waddr_r == TCC_OFS_IRQ_MASK)
			imask_nxt = hwdata[TCC_IRQ_EV_BIT];

		// flag: event wins over clear; a one written is ignored
		flag_nxt = flag_r;
		if (wr_csc && !hwdata[TCC_CSC_FLAG_BIT] && armed_r)
			flag_nxt = 1'b0;
		if (ev)
			flag_nxt = 1'b1;

		armed_nxt = armed_r;
		if (wr_csc || ev)
			armed_nxt = 1'b0;
		if (rd_csc && flag_nxt)
			armed_nxt = 1'b1;

		ist_nxt = ist_r;
		if (wpend_r && waddr_r == TCC_OFS_IRQ_STAT &&
			hwdata[TCC_IRQ_EV_BIT])
			ist_nxt = 1'b0;
		if (ev)
			ist_nxt = 1'b1;
		irq_nxt = ist_nxt && imask_nxt;
		chirq_nxt = flag_nxt && ie_nxt;

		// pin action on match or counter wrap
		pout_nxt = pout_r;
		unique case (mode)
			TCC_M_CAPTURE: pout_nxt = pout_r;
			TCC_M_COMPARE: begin
				if (cnt_match) begin
					unique case (els_r)
						TCC_ELS_OFF:    pout_nxt = pout_r;
						TCC_ELS_TOGGLE: pout_nxt = !pout_r;
						TCC_ELS_CLEAR:  pout_nxt = 1'b0;
						TCC_ELS_SET:    pout_nxt = 1'b1;
					endcase
				end
			end
			TCC_M_EPWM: begin
				if (cnt_wrap)
					pout_nxt = (els_r == TCC_ELS_CLEAR);
				if (cnt_match)
					pout_nxt = (els_r != TCC_ELS_CLEAR);
			end
			TCC_M_CPWM: begin
				if (cnt_match)
					pout_nxt = cnt_down ^ (els_r != TCC_ELS_CLEAR);
			end
		endcase

		mode_nxt = tcc_mode(cpwm_nxt, msh_nxt, msl_nxt);
		poe_nxt = (els_nxt != TCC_ELS_OFF) &&
			(mode_nxt != TCC_M_CAPTURE);

		// read data reflect writes landing in this same cycle
		rdata_nxt = 32'h0000_0000;
		if (acc && !hwrite) begin
			unique case (haddr[7:0])
				TCC_OFS_CSC: begin
					rdata_nxt[TCC_CSC_FLAG_BIT] = flag_nxt;
					rdata_nxt[TCC_CSC_IE_BIT]   = ie_nxt;
					rdata_nxt[TCC_CSC_MSH_BIT]  = msh_nxt;
					rdata_nxt[TCC_CSC_MSL_BIT]  = msl_nxt;
					rdata_nxt[TCC_CSC_ELS_HI:TCC_CSC_ELS_LO] = els_nxt;
				end
				TCC_OFS_CTRL:     rdata_nxt[TCC_CTRL_CPWM_BIT] = cpwm_nxt;
				TCC_OFS_IRQ_STAT: rdata_nxt[TCC_IRQ_EV_BIT] = ist_nxt;
				TCC_OFS_IRQ_MASK: rdata_nxt[TCC_IRQ_EV_BIT] = imask_nxt;
				TCC_OFS_PIN_STAT: begin
					rdata_nxt[TCC_PIN_LVL_BIT] = pin_level;
					rdata_nxt[TCC_PIN_OUT_BIT] = pout_nxt;
					rdata_nxt[TCC_PIN_OE_BIT]  = poe_nxt;
				end
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_r  <= TCC_CSC_RST[TCC_CSC_FLAG_BIT];
			ie_r    <= TCC_CSC_RST[TCC_CSC_IE_BIT];
			msh_r   <= TCC_CSC_RST[TCC_CSC_MSH_BIT];
			msl_r   <= TCC_CSC_RST[TCC_CSC_MSL_BIT];
			els_r   <= TCC_CSC_RST[TCC_CSC_ELS_HI:TCC_CSC_ELS_LO];
			cpwm_r  <= TCC_CTRL_RST;
			armed_r <= 1'b0;
			ist_r   <= TCC_IRQ_RST;
			imask_r <= TCC_IRQ_RST;
			pout_r  <= TCC_PIN_RST;
			poe_r   <= 1'b0;
			chirq_r <= 1'b0;
			irq_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
			wpend_r <= 1'b0;
			waddr_r <= 8'h00;
			hrdy_r  <= 1'b1;
		end else begin
			flag_r  <= flag_nxt;
			ie_r    <= ie_nxt;
			msh_r   <= msh_nxt;
			msl_r   <= msl_nxt;
			els_r   <= els_nxt;
			cpwm_r  <= cpwm_nxt;
			armed_r <= armed_nxt;
			ist_r   <= ist_nxt;
			imask_r <= imask_nxt;
			pout_r  <= pout_nxt;
			poe_r   <= poe_nxt;
			chirq_r <= chirq_nxt;
			irq_r   <= irq_nxt;
			rdata_r <= rdata_nxt;
			wpend_r <= wpend_nxt;
			waddr_r <= waddr_nxt;
			hrdy_r  <= 1'b1;
		end
	end

	assign hrdata     = rdata_r;
	assign hreadyout  = hrdy_r;
	assign hresp      = TCC_HRESP_OKAY;
	assign ch_pin_out = pout_r;
	assign ch_pin_oe  = poe_r;
	assign ch_irq     = chirq_r;
	assign irq        = irq_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_cap_flag;
		(mode == TCC_M_CAPTURE && els_r != TCC_ELS_OFF && edge_hit)
			|=> flag_r;
	endproperty
	a_cap_flag: assert property (p_cap_flag)
		else $error("capture edge did not set flag");

	property p_cmp_flag;
		(mode inside {TCC_M_COMPARE, TCC_M_EPWM}) && cnt_match |=> flag_r;
	endproperty
	a_cmp_flag: assert property (p_cmp_flag)
		else $error("compare match did not set flag");

	property p_cpwm_flag;
		mode == TCC_M_CPWM && cnt_match |=> flag_r && ch_irq == ie_r;
	endproperty
	a_cpwm_flag: assert property (p_cpwm_flag)
		else $error("center match did not set flag");

	property p_irq_level;
		ch_irq == (flag_r && ie_r);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("channel irq not flag and enable");

	property p_clear_seq;
		$fell(flag_r) |-> $past(armed_r) && $past(wr_csc);
	endproperty
	a_clear_seq: assert property (p_clear_seq)
		else $error("flag cleared without read then write");

	property p_restart;
		armed_r && ev && !rd_csc |=> flag_r && !armed_r;
	endproperty
	a_restart: assert property (p_restart)
		else $error("new event lost during clear sequence");

	property p_write_one;
		wr_csc && hwdata[TCC_CSC_FLAG_BIT] && !ev |=> $stable(flag_r);
	endproperty
	a_write_one: assert property (p_write_one)
		else $error("write of one set the flag");

	property p_ie_write;
		wr_csc |=> ie_r == $past(hwdata[TCC_CSC_IE_BIT]);
	endproperty
	a_ie_write: assert property (p_ie_write)
		else $error("interrupt enable not written");

	property p_gpio;
		ch_pin_oe |-> els_r != TCC_ELS_OFF && mode != TCC_M_CAPTURE;
	endproperty
	a_gpio: assert property (p_gpio)
		else $error("pin driven while released");

	property p_toggle;
		mode == TCC_M_COMPARE && els_r == TCC_ELS_TOGGLE && cnt_match
			|=> ch_pin_out != $past(ch_pin_out);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("compare toggle missing");

	property p_center;
		cpwm_r |-> mode == TCC_M_CPWM;
	endproperty
	a_center: assert property (p_center)
		else $error("center select did not force center mode");

endmodule
`default_nettype wire

/* File: verification/tcc_far_model.sv */
// far side of one timer channel: shared counter and the channel pin
// assumes one clock shared with the channel; one period per start pulse
`timescale 1ns/1ps
`default_nettype none
module tcc_far_model #(
	parameter int PER = 8
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       start,
	input  wire logic       center,
	input  wire logic       pin_lvl,
	input  wire logic [7:0] cmp,
	input  wire logic       ch_pin_out,
	input  wire logic       ch_pin_oe,
	output logic            ch_pin_in,
	output logic            cnt_match,
	output logic            cnt_wrap,
	output logic            cnt_down,
	output logic            busy
);
	logic [7:0] cnt;

	// ==========================================================
	// pin wire: channel drives while enabled, else external level
	assign ch_pin_in = ch_pin_oe ? ch_pin_out : pin_lvl;

	// ==========================================================
	// counter: up to PER-1, then down to 0 when center is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy      <= 1'b0;
			cnt       <= 8'h00;
			cnt_down  <= 1'b0;
			cnt_match <= 1'b0;
			cnt_wrap  <= 1'b0;
		end else begin
			cnt_match <= 1'b0;
			cnt_wrap  <= 1'b0;
			if (start && !busy) begin
				busy     <= 1'b1;
				cnt      <= 8'h00;
				cnt_wrap <= 1'b1;
			end else if (busy && !cnt_down) begin
				if (cnt == 8'(PER - 1)) begin
					cnt_down <= center;
					busy     <= center;
				end else begin
					cnt       <= cnt + 8'h01;
					cnt_match <= (cnt + 8'h01 == cmp);
				end
			end else if (busy) begin
				if (cnt == 8'h00) begin
					cnt_down <= 1'b0;
					busy     <= 1'b0;
				end else begin
					cnt       <= cnt - 8'h01;
					cnt_match <= (cnt - 8'h01 == cmp);
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/test_timer_channel_control.sv */
// self-checking bench of the timer channel control block
// assumes the far side model and the channel package
`timescale 1ns/1ps
`default_nettype none
module test_timer_channel_control;
	import tcc_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        start = 1'b0, center = 1'b0, pin_lvl = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w;
	logic [31:0] seed = 32'h997D;
	logic [1:0]  htrans = 2'h0, hresp;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  cmp = 8'h03;
	logic        hreadyout, ch_pin_in, ch_pin_out, ch_pin_oe, cnt_match;
	logic        cnt_wrap, cnt_down, ch_irq, irq, busy, po, cen;
	logic [1:0]  cd;
	int          n_errors = 0, checks = 0;

	// ==========================================================
	// clock, design and far side
	always #2 hclk = ~hclk;
	tcc_channel dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ch_pin_in(ch_pin_in),
		.ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
		.cnt_match(cnt_match), .cnt_wrap(cnt_wrap), .cnt_down(cnt_down),
		.ch_irq(ch_irq), .irq(irq));
	tcc_far_model #(.PER(8)) far_u (.hclk(hclk), .hresetn(hresetn),
		.start(start), .center(center), .pin_lvl(pin_lvl), .cmp(cmp),
		.ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
		.ch_pin_in(ch_pin_in), .cnt_match(cnt_match), .cnt_wrap(cnt_wrap),
		.cnt_down(cnt_down), .busy(busy));

	// ==========================================================
	// expectations
	function automatic logic [31:0] cfg(input logic ie, input logic mh,
		input logic ml, input logic [1:0] els);
		return {25'h0, ie, mh, ml, els, 2'h0};
	endfunction
	function automatic logic [31:0] csc(input logic f, input logic [31:0] v);
		return {24'h0, f, v[6:2], 2'h0};
	endfunction
	function automatic logic hit(input logic [1:0] c, input logic rise);
		return (c == 2'h3) || (c == 2'h1 && rise) || (c == 2'h2 && !rise);
	endfunction

	// ==========================================================
	// bus and check tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic we, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= we;
		htrans <= TCC_HTRANS_NSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
		chk({30'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, rd);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask
	task automatic run_period();
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		@(posedge hclk);
		while (busy) @(posedge hclk);
		repeat (3) @(posedge hclk);
	endtask
	task automatic stop_test();
		$display("errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		stop_test();
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h0);
		for (int i = 0; i < 6; i++) begin
			w = $random(seed);
			wr(TCC_OFS_CSC, w);
			rdc(TCC_OFS_CSC, csc(1'b0, w));
		end
		// capture on each edge code, rising then falling
		for (int k = 0; k < 8; k++) begin
			cd = 2'(k / 2);
			w = cfg(1'b1, 1'b0, 1'b0, cd);
			wr(TCC_OFS_CSC, w);
			pin_lvl <= (k % 2 == 0);
			repeat (8) @(posedge hclk);
			chk({31'h0, ch_irq}, {31'h0, hit(cd, k % 2 == 0)});
			rdc(TCC_OFS_CSC, csc(hit(cd, k % 2 == 0), w));
		end
		// compare actions: set, toggle, toggle, clear, software only
		po = 1'b0;
		for (int k = 0; k < 5; k++) begin
			cd = (k == 0) ? 2'h3 : (k < 3) ? 2'h1 : (k == 3) ? 2'h2 : 2'h0;
			po = (cd == 2'h3) | ((cd == 2'h1) ? !po : (cd == 2'h0) & po);
			w = cfg(1'b0, 1'b0, 1'b1, cd);
			wr(TCC_OFS_CSC, w);
			run_period();
			rdc(TCC_OFS_CSC, csc(1'b1, w));
			rdc(TCC_OFS_PIN_STAT, {29'h0, cd != 2'h0, po, po});
			chk({30'h0, ch_pin_oe, ch_pin_out}, {30'h0, cd != 0, po});
		end
		// clear sequence: write without read, event in between
		w = cfg(1'b0, 1'b0, 1'b1, 2'h0);
		wr(TCC_OFS_CSC, w);
		run_period();
		wr(TCC_OFS_CSC, w);
		rdc(TCC_OFS_CSC, csc(1'b1, w));
		chk({31'h0, ch_irq}, 32'h0);
		run_period();
		wr(TCC_OFS_CSC, w);
		rdc(TCC_OFS_CSC, csc(1'b1, w));
		wr(TCC_OFS_CSC, w | 32'h80);
		rdc(TCC_OFS_CSC, csc(1'b1, w));
		wr(TCC_OFS_CSC, w);
		rdc(TCC_OFS_CSC, csc(1'b0, w));
		// module interrupt: status, mask, write one to clear
		wr(TCC_OFS_IRQ_MASK, 32'h0);
		wr(TCC_OFS_IRQ_STAT, 32'h1);
		run_period();
		chk({31'h0, irq}, 32'h0);
		rdc(TCC_OFS_IRQ_STAT, 32'h1);
		wr(TCC_OFS_IRQ_MASK, 32'h1);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		wr(TCC_OFS_IRQ_STAT, 32'h1);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rdc(TCC_OFS_IRQ_STAT, 32'h0);
		// edge and center PWM, both polarities
		for (int k = 0; k < 4; k++) begin
			cen = (k > 1);
			cd = (k % 2 == 1) ? 2'h1 : 2'h2;
			po = cen ? !cd[0] : cd[0];
			wr(TCC_OFS_CTRL, {31'h0, cen});
			center <= cen;
			w = cfg(1'b0, !cen, 1'b0, cd);
			wr(TCC_OFS_CSC, w);
			run_period();
			rdc(TCC_OFS_CSC, csc(1'b1, w));
			rdc(TCC_OFS_PIN_STAT, {29'h0, 1'b1, po, po});
			chk({30'h0, ch_pin_oe, ch_pin_out}, {30'h0, 1'b1, po});
		end
		// reset after the last PWM period clears flag, enable and pin drive
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(TCC_OFS_CSC, 32'h0);
		chk({30'h0, ch_pin_oe, ch_irq}, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
